// *** src/tec_top.v ***
// tec_top.v: one 8-bit and one 16-bit timer/event counter with preload,
// overflow flags, wake pulse and frequency divider pin
// assumes option inputs are static straps and tick inputs are clk_in pulses
// Notes on behaviour
// - pulse-width mode measures once; result holds until enable set again
// - pulse-width count starts on the selected edge, not on a level
// - pulse-width overflow reloads from preload and raises the flag
// - counter advances only while its enable bit is 1
// - pulse-width end clears enable; other modes clear only by software
// - overflow of either counter is a wake-up source
// - a strap routes exactly one counter overflow to the divider pin
// - interrupt enable at 0 blocks the counter interrupt in any mode
// - preload write while counter off loads the counter too
// - preload write while running changes only preload, used at overflow
// - reading the counter blocks its count clock for that cycle
// - counter 1 bit 3 picks active edge: 0 rising, 1 falling
// - counter 1 bit 5 picks clock: 0 strap source, 1 sysclk/4
// - mode bits 7:6: 01 event, 10 timer, 11 pulse width, 00 unused
// - counter 1 control bits 2:0 read as zero
// - divider pin is 0 when port bit is 1, else divider signal
// - divider rate is count clock over 2*(256-N) or 2*(65536-N)
// - count up to all ones, reload from preload, set overflow flag
// - low byte write buffered, high byte write loads both, high read latches low
// - pulse width counts from active edge until input returns, clears enable
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "tec_map.vh"
module tec_top (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  input  wire       cnt0_pin_in,
  input  wire       cnt1_pin_in,
  input  wire       rtc_tick_in,
  input  wire       tb_tick_in,
  input  wire       opt0_div4_in,
  input  wire [1:0] opt1_src_in,
  input  wire       pfd_sel_in,
  output reg  [7:0] rdata_out,
  output reg        irq0_out,
  output reg        irq1_out,
  output reg        wake_out,
  output reg        pfd_pin_out
);
  // measurement states, one-hot
  localparam ST_IDLE = 2'b01;
  localparam ST_MEAS = 2'b10;

  // active edge: 0 rising, 1 falling
  function act_edge;
    input esel;
    input rise;
    input fall;
    begin
      act_edge = esel ? fall : rise;
    end
  endfunction

  // count pulse for the selected mode
  function mode_tick;
    input [1:0] mode;
    input       ext;
    input       itk;
    input       meas;
    begin
      case (mode)
        `TEC_MODE_EVT: mode_tick = ext;
        `TEC_MODE_TMR: mode_tick = itk;
        `TEC_MODE_PWM: mode_tick = itk & meas;
        default:       mode_tick = 1'b0;
      endcase
    end
  endfunction

  // next measurement state: start on the selected edge, end on the opposite one
  function [1:0] meas_next;
    input [1:0] st;
    input       pwm;
    input       act;
    input       opp;
    begin
      case (st)
        ST_IDLE: meas_next = (pwm & act) ? ST_MEAS : ST_IDLE;
        ST_MEAS: meas_next = (~pwm | opp) ? ST_IDLE : ST_MEAS;
        default: meas_next = ST_IDLE;
      endcase
    end
  endfunction

  reg  [7:0]  ctl0_reg;
  reg  [7:0]  ctl1_reg;
  reg  [7:0]  cnt0_reg;
  reg  [7:0]  pre0_reg;
  reg  [15:0] cnt1_reg;
  reg  [15:0] pre1_reg;
  reg  [7:0]  lowbuf_reg;
  reg  [1:0]  st0_reg;
  reg  [1:0]  st1_reg;
  reg  [1:0]  st0_next;
  reg  [1:0]  st1_next;
  reg  [1:0]  div_reg;
  reg         ovf0_reg;
  reg         en0_reg;
  reg         en1_reg;
  reg         flg0_reg;
  reg         flg1_reg;
  reg         port3_reg;
  reg         pfd_reg;
  reg         itk1;
  reg  [7:0]  rd_next;
  wire        rise0;
  wire        fall0;
  wire        rise1;
  wire        fall1;

  // pin synchronisers and edge detectors
  tec_sync u_sync0 (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (cnt0_pin_in),
    .level_out (),
    .rise_out  (rise0),
    .fall_out  (fall0)
  );
  tec_sync u_sync1 (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (cnt1_pin_in),
    .level_out (),
    .rise_out  (rise1),
    .fall_out  (fall1)
  );

  // address decode of the register port
  wire wr_c0  = wr_in & (addr_in == `TEC_A_CNT0);
  wire wr_k0  = wr_in & (addr_in == `TEC_A_CTL0);
  wire wr_h1  = wr_in & (addr_in == `TEC_A_CNT1H);
  wire wr_l1  = wr_in & (addr_in == `TEC_A_CNT1L);
  wire wr_k1  = wr_in & (addr_in == `TEC_A_CTL1);
  wire wr_i1  = wr_in & (addr_in == `TEC_A_IRQ1);
  wire wr_i2  = wr_in & (addr_in == `TEC_A_IRQ2);
  wire wr_pa  = wr_in & (addr_in == `TEC_A_PORTA);
  wire rd_c0  = rd_in & (addr_in == `TEC_A_CNT0);
  wire rd_h1  = rd_in & (addr_in == `TEC_A_CNT1H);

  // control fields
  wire [1:0] mode0 = ctl0_reg[7:6];
  wire [1:0] mode1 = ctl1_reg[7:6];
  wire       on0   = ctl0_reg[`TEC_B_ON];
  wire       on1   = ctl1_reg[`TEC_B_ON];
  wire       te0   = ctl0_reg[`TEC_B_EDGE];
  wire       te1   = ctl1_reg[`TEC_B_EDGE];

  // selected and opposite edges of each input
  wire act0 = act_edge(te0, rise0, fall0);
  wire opp0 = act_edge(te0, fall0, rise0);
  wire act1 = act_edge(te1, rise1, fall1);
  wire opp1 = act_edge(te1, fall1, rise1);

  // system clock divided by four as an enable pulse
  wire div4 = (div_reg == `TEC_DIV4_LAST);
  always @(posedge clk_in) begin
    if (rst_in) begin
      div_reg <= 2'b00;
    end else begin
      div_reg <= div_reg + 2'b01;
    end
  end

  // internal clock of counter 0: rtc tick or strap-chosen system rate
  wire itk0 = ctl0_reg[`TEC_B_SRC] ? (opt0_div4_in ? div4 : 1'b1)
                                   : rtc_tick_in;

  // internal clock of counter 1
  always @* begin
    if (ctl1_reg[`TEC_B_SRC]) begin
      itk1 = div4;
    end else begin
      case (opt1_src_in)
        `TEC_S1_OVF0: itk1 = ovf0_reg;
        `TEC_S1_SYS:  itk1 = 1'b1;
        `TEC_S1_TB:   itk1 = tb_tick_in;
        default:      itk1 = 1'b0;
      endcase
    end
  end

  // count pulses, gated by enable and by a counter read
  wire meas0 = (st0_reg == ST_MEAS);
  wire meas1 = (st1_reg == ST_MEAS);
  wire tick0 = on0 & ~rd_c0 & mode_tick(mode0, act0, itk0, meas0);
  wire tick1 = on1 & ~rd_h1 & mode_tick(mode1, act1, itk1, meas1);
  wire ovf0  = tick0 & (cnt0_reg == 8'hff);
  wire ovf1  = tick1 & (cnt1_reg == 16'hffff);

  // end of a pulse-width measurement
  wire pwm0  = on0 & (mode0 == `TEC_MODE_PWM);
  wire pwm1  = on1 & (mode1 == `TEC_MODE_PWM);
  wire done0 = pwm0 & meas0 & opp0;
  wire done1 = pwm1 & meas1 & opp1;

  // measurement state of both counters
  always @* begin
    st0_next = meas_next(st0_reg, pwm0, act0, opp0);
    st1_next = meas_next(st1_reg, pwm1, act1, opp1);
  end

  // control registers; measurement end clears the enable bit
  always @(posedge clk_in) begin
    if (rst_in) begin
      ctl0_reg <= `TEC_CTL_RST;
      ctl1_reg <= `TEC_CTL_RST;
      st0_reg  <= ST_IDLE;
      st1_reg  <= ST_IDLE;
    end else begin
      st0_reg <= st0_next;
      st1_reg <= st1_next;
      if (wr_k0) begin
        ctl0_reg <= {wdata_in[7:3], 3'b000};
      end else if (done0) begin
        ctl0_reg[`TEC_B_ON] <= 1'b0;
      end
      if (wr_k1) begin
        ctl1_reg <= {wdata_in[7:3], 3'b000};
      end else if (done1) begin
        ctl1_reg[`TEC_B_ON] <= 1'b0;
      end
    end
  end

  // counter 0 and its preload
  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt0_reg <= 8'h00;
      pre0_reg <= 8'h00;
      ovf0_reg <= 1'b0;
    end else begin
      ovf0_reg <= ovf0;
      if (wr_c0) begin
        pre0_reg <= wdata_in;
      end
      if (wr_c0 & ~on0) begin
        cnt0_reg <= wdata_in;
      end else if (ovf0) begin
        cnt0_reg <= pre0_reg;
      end else if (tick0) begin
        cnt0_reg <= cnt0_reg + 8'h01;
      end
    end
  end

  // counter 1, its preload and the low-byte buffer
  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt1_reg   <= 16'h0000;
      pre1_reg   <= 16'h0000;
      lowbuf_reg <= 8'h00;
    end else begin
      if (wr_l1) begin
        lowbuf_reg <= wdata_in;
      end else if (rd_h1) begin
        lowbuf_reg <= cnt1_reg[7:0];
      end
      if (wr_h1) begin
        pre1_reg <= {wdata_in, lowbuf_reg};
      end
      if (wr_h1 & ~on1) begin
        cnt1_reg <= {wdata_in, lowbuf_reg};
      end else if (ovf1) begin
        cnt1_reg <= pre1_reg;
      end else if (tick1) begin
        cnt1_reg <= cnt1_reg + 16'h0001;
      end
    end
  end

  // overflow flags: hardware set wins over a software clear
  always @(posedge clk_in) begin
    if (rst_in) begin
      en0_reg  <= 1'b0;
      en1_reg  <= 1'b0;
      flg0_reg <= 1'b0;
      flg1_reg <= 1'b0;
      port3_reg <= `TEC_PORT3_RST;
    end else begin
      if (wr_i1) begin
        en0_reg  <= wdata_in[`TEC_B_EN0];
        flg0_reg <= wdata_in[`TEC_B_FLG0] | ovf0;
      end else if (ovf0) begin
        flg0_reg <= 1'b1;
      end
      if (wr_i2) begin
        en1_reg  <= wdata_in[`TEC_B_EN1];
        flg1_reg <= wdata_in[`TEC_B_FLG1] | ovf1;
      end else if (ovf1) begin
        flg1_reg <= 1'b1;
      end
      if (wr_pa) begin
        port3_reg <= wdata_in[`TEC_B_PORT3];
      end
    end
  end

  // interrupt requests and wake pulse
  always @(posedge clk_in) begin
    if (rst_in) begin
      irq0_out <= 1'b0;
      irq1_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      irq0_out <= flg0_reg & en0_reg;
      irq1_out <= flg1_reg & en1_reg;
      wake_out <= ovf0 | ovf1;
    end
  end

  // divider: toggles on each overflow of the strapped counter
  wire ovf_sel = pfd_sel_in ? ovf1 : ovf0;
  always @(posedge clk_in) begin
    if (rst_in) begin
      pfd_reg     <= 1'b0;
      pfd_pin_out <= 1'b0;
    end else begin
      if (ovf_sel) begin
        pfd_reg <= ~pfd_reg;
      end
      pfd_pin_out <= port3_reg ? 1'b0 : pfd_reg;
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    case (addr_in)
      `TEC_A_CNT0:  rd_next = cnt0_reg;
      `TEC_A_CTL0:  rd_next = ctl0_reg;
      `TEC_A_CNT1H: rd_next = cnt1_reg[15:8];
      `TEC_A_CNT1L: rd_next = lowbuf_reg;
      `TEC_A_CTL1:  rd_next = ctl1_reg;
      `TEC_A_IRQ1:  rd_next = {1'b0, flg0_reg, 2'b00, en0_reg, 3'b000};
      `TEC_A_IRQ2:  rd_next = {3'b000, flg1_reg, 3'b000, en1_reg};
      `TEC_A_PORTA: rd_next = {4'h0, port3_reg, 3'b000};
      default:      rd_next = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rd_next;
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule // tec_top

// *** inc/tec_map.vh ***
// tec_map.vh: register offsets, field positions, reset values and codes
// for the two timer/event counters; definitions only
`ifndef TEC_MAP_VH
`define TEC_MAP_VH
// register offsets on the byte-wide register port
`define TEC_A_IRQ1    8'h0b
`define TEC_A_CNT0    8'h0d
`define TEC_A_CTL0    8'h0e
`define TEC_A_CNT1H   8'h0f
`define TEC_A_CNT1L   8'h10
`define TEC_A_CTL1    8'h11
`define TEC_A_PORTA   8'h12
`define TEC_A_IRQ2    8'h1e
// control register fields
`define TEC_B_EDGE    3
`define TEC_B_ON      4
`define TEC_B_SRC     5
`define TEC_MODE_EVT  2'b01
`define TEC_MODE_TMR  2'b10
`define TEC_MODE_PWM  2'b11
`define TEC_CTL_RST   8'h08
// interrupt control fields
`define TEC_B_EN0     3
`define TEC_B_FLG0    6
`define TEC_B_EN1     0
`define TEC_B_FLG1    4
// port data bit that gates the divider pin
`define TEC_B_PORT3   3
`define TEC_PORT3_RST 1'b1
// clock source option codes of counter 1
`define TEC_S1_OVF0   2'b00
`define TEC_S1_SYS    2'b01
`define TEC_S1_TB     2'b10
// system clock divided by four
`define TEC_DIV4_LAST 2'b11
`endif

// *** src/tec_sync.v ***
// tec_sync.v: two-flop synchroniser with edge detection for one pin
// assumes the pin is asynchronous to clk_in and idles high on its pull-up
`timescale 1ns/100ps
module tec_sync (
  input  wire clk_in,
  input  wire rst_in,
  input  wire pin_in,
  output wire level_out,
  output wire rise_out,
  output wire fall_out
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // first flop feeds only the second; third flop gives the edge history
  always @(posedge clk_in) begin
    if (rst_in) begin
      // pull-up level, so no false edge follows reset
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edge pulses, one cycle each
  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~last_reg;
  assign fall_out  = ~sync_reg & last_reg;
endmodule // tec_sync

// *** tb/tec_pulse_src.sv ***
// tec_pulse_src.sv: far-side model driving the counter input pin
// assumes go_in is a one-cycle request from the bench in the clk_in domain
`timescale 1ns/100ps
module tec_pulse_src (
  input  wire        clk_in,
  input  wire        go_in,
  input  wire [15:0] width_in,
  input  wire        idle_in,
  output reg         pin_out,
  output wire        busy_out
);
  reg [15:0] left_reg = 16'h0000;
  assign busy_out = (left_reg != 16'h0000);
  // active level for width cycles, idle level otherwise
  always @(posedge clk_in) begin
    if (go_in)
      left_reg <= width_in;
    else if (busy_out)
      left_reg <= left_reg - 16'h0001;
    pin_out <= busy_out ? ~idle_in : idle_in;
  end
endmodule // tec_pulse_src

// *** tb/tec_top_asserts.sv ***
// tec_top_asserts.sv: port-level checks of the timer/event counter block
// assumes one-cycle strobes on the register port, never both at once
`timescale 1ns/100ps
`include "tec_map.vh"
module tec_top_asserts (
  input wire       clk_in,
  input wire       rst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  input wire       irq0_out,
  input wire       irq1_out,
  input wire       wake_out,
  input wire       pfd_pin_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // two low-byte reads with an idle cycle between
  sequence low_twice;
    (rd_in && addr_in == `TEC_A_CNT1L) ##1 (!rd_in && !wr_in)
      ##1 (rd_in && addr_in == `TEC_A_CNT1L);
  endsequence
  // port write that forces the divider pin low
  sequence port_off;
    wr_in && addr_in == `TEC_A_PORTA && wdata_in[`TEC_B_PORT3];
  endsequence
  AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not zero outside read answer");
  AST_CTL1_LOW_ZERO: assert property (
    rd_in && addr_in == `TEC_A_CTL1 |=> rdata_out[2:0] == 3'h0)
    else $error("control low bits not zero");
  AST_IRQ0_MASK: assert property (
    wr_in && addr_in == `TEC_A_IRQ1 && !wdata_in[3] |-> ##2 !irq0_out)
    else $error("counter 0 interrupt not masked");
  AST_IRQ1_MASK: assert property (
    wr_in && addr_in == `TEC_A_IRQ2 && !wdata_in[0] |-> ##2 !irq1_out)
    else $error("counter 1 interrupt not masked");
  AST_IRQ0_CAUSE: assert property (
    $rose(irq0_out) |-> $past(wake_out) || $past(wr_in && addr_in == `TEC_A_IRQ1, 2))
    else $error("counter 0 interrupt without cause");
  AST_IRQ1_CAUSE: assert property (
    $rose(irq1_out) |-> $past(wake_out) || $past(wr_in && addr_in == `TEC_A_IRQ2, 2))
    else $error("counter 1 interrupt without cause");
  AST_LOW_REREAD: assert property (low_twice |=> rdata_out == $past(rdata_out, 2))
    else $error("buffered low byte changed");
  AST_PFD_OFF: assert property (port_off |-> ##2 !pfd_pin_out)
    else $error("divider pin not low");
  AST_PFD_TOGGLE: assert property (
    $changed(pfd_pin_out) |-> $past(wake_out) || $past(wr_in && addr_in == `TEC_A_PORTA, 2))
    else $error("divider pin changed without overflow");
endmodule // tec_top_asserts
bind tec_top tec_top_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .irq0_out(irq0_out), .irq1_out(irq1_out), .wake_out(wake_out),
  .pfd_pin_out(pfd_pin_out));

// *** tb/timer_event_counter_pfd_test.sv ***
// timer_event_counter_pfd_test.sv: register-level test of both counters
// assumes straps: counter 0 fast source is sysclk, divider fed by counter 0
`timescale 1ns/100ps
`include "tec_map.vh"
`define CHK(nm, e, g) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
  err_total = err_total + 1; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module timer_event_counter_pfd_test;
  reg        clk_in = 1'b0;
  reg        rst_in = 1'b1;
  reg  [7:0] addr_in = 8'h00;
  reg  [7:0] wdata_in = 8'h00;
  reg        wr_in = 1'b0;
  reg        rd_in = 1'b0;
  reg        go = 1'b0;
  reg        idle = 1'b1;
  reg [15:0] wid = 16'h0000;
  wire [7:0] rdata_out;
  wire       irq0_out, irq1_out, wake_out, pfd_pin_out, pin, busy;
  integer    err_total = 0;
  integer    total_checks = 0;
  integer    n;
  reg  [7:0] v, w;
  // divider fed by counter 0 through the pfd_sel_in strap
  tec_top dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .cnt0_pin_in(pin), .cnt1_pin_in(pin),
    .rtc_tick_in(1'b0), .tb_tick_in(1'b0), .opt0_div4_in(1'b0), .opt1_src_in(2'b01),
    .pfd_sel_in(1'b0),
    .rdata_out(rdata_out), .irq0_out(irq0_out), .irq1_out(irq1_out),
    .wake_out(wake_out), .pfd_pin_out(pfd_pin_out));
  tec_pulse_src u_src (.clk_in(clk_in), .go_in(go), .width_in(wid), .idle_in(idle),
    .pin_out(pin), .busy_out(busy));
  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // one-cycle register write
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
    end
  endtask
  // one-cycle register read, data taken in the answer cycle
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
    end
  endtask
  task rc(input [7:0] a, input [7:0] e);
    begin
      rd(a, v);
      `CHK("register read", e, v)
    end
  endtask
  // bounded wait for the next wake pulse, n counts cycles
  task wk;
    begin
      n = 0;
      do begin
        @(posedge clk_in);
        #1 n = n + 1;
        if (n > 300) begin
          err_total = err_total + 1;
          report_and_stop;
        end
      end while (wake_out !== 1'b1);
    end
  endtask
  // one pulse from the far side, then a quiet gap
  task pulse(input [15:0] len);
    integer k;
    begin
      @(posedge clk_in);
      go <= 1'b1;
      wid <= len;
      @(posedge clk_in);
      go <= 1'b0;
      #1;
      for (k = 0; busy === 1'b1 && k < 1000; k = k + 1)
        @(posedge clk_in);
      if (k >= 1000) begin
        err_total = err_total + 1;
        report_and_stop;
      end
      repeat (8) @(posedge clk_in);
    end
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    rc(`TEC_A_CTL0, `TEC_CTL_RST);
    rc(`TEC_A_CTL1, `TEC_CTL_RST);
    rc(8'h00, 8'h00);
    wr(`TEC_A_CTL0, 8'hb0);
    wr(`TEC_A_CTL0, 8'h08);
    wr(`TEC_A_CNT0, 8'h5a);
    rc(`TEC_A_CNT0, 8'h5a);
    repeat (10) @(posedge clk_in);
    rc(`TEC_A_CNT0, 8'h5a);
    wr(`TEC_A_CNT0, 8'hf0);
    wr(`TEC_A_IRQ1, 8'h08);
    wr(`TEC_A_PORTA, 8'h00);
    wr(`TEC_A_CTL0, 8'hb0);
    wk;
    // interrupt and divider pin follow the wake pulse by one cycle
    @(posedge clk_in);
    #1 `CHK("irq0", 1'b1, irq0_out)
    `CHK("pfd", 1'b1, pfd_pin_out)
    wr(`TEC_A_CNT0, 8'h80);
    rc(`TEC_A_CTL0, 8'hb0);
    rc(`TEC_A_IRQ1, 8'h48);
    wk;
    `CHK("old reload", 1'b1, n < 16)
    wk;
    `CHK("period", 128, n)
    @(posedge clk_in);
    #1 `CHK("pfd", 1'b1, pfd_pin_out)
    wr(`TEC_A_IRQ1, 8'h00);
    repeat (3) @(posedge clk_in);
    #1 `CHK("irq0", 1'b0, irq0_out)
    wr(`TEC_A_PORTA, 8'h08);
    repeat (3) @(posedge clk_in);
    #1 `CHK("pfd", 1'b0, pfd_pin_out)
    wr(`TEC_A_CTL0, 8'h08);
    wr(`TEC_A_IRQ2, 8'h11);
    repeat (3) @(posedge clk_in);
    #1 `CHK("irq1", 1'b1, irq1_out)
    wr(`TEC_A_IRQ2, 8'h00);
    repeat (3) @(posedge clk_in);
    #1 `CHK("irq1", 1'b0, irq1_out)
    wr(`TEC_A_CNT1L, 8'h00);
    wr(`TEC_A_CNT1H, 8'h00);
    wr(`TEC_A_CTL1, 8'h58);
    repeat (3) pulse(16'd6);
    idle <= 1'b0;
    repeat (8) @(posedge clk_in);
    rc(`TEC_A_CNT1H, 8'h00);
    rc(`TEC_A_CNT1L, 8'h04);
    rc(`TEC_A_CNT1L, 8'h04);
    wr(`TEC_A_CTL1, 8'h08);
    wr(`TEC_A_CNT1L, 8'h00);
    wr(`TEC_A_CNT1H, 8'h00);
    idle <= 1'b1;
    repeat (8) @(posedge clk_in);
    wr(`TEC_A_CTL1, 8'hf0);
    repeat (40) @(posedge clk_in);
    rc(`TEC_A_CNT1H, 8'h00);
    rc(`TEC_A_CNT1L, 8'h00);
    idle <= 1'b0;
    repeat (8) @(posedge clk_in);
    pulse(16'd400);
    rc(`TEC_A_CTL1, 8'he0);
    rc(`TEC_A_CNT1H, 8'h00);
    rd(`TEC_A_CNT1L, w);
    `CHK("width", 1'b1, w >= 8'd99 && w <= 8'd101)
    pulse(16'd400);
    rc(`TEC_A_CNT1H, 8'h00);
    rc(`TEC_A_CNT1L, w);
    // counter 0 in event mode counts rising edges of its pin
    wr(`TEC_A_CNT0, 8'h00);
    wr(`TEC_A_CTL0, 8'h50);
    repeat (2) pulse(16'd6);
    rc(`TEC_A_CNT0, 8'h02);
    report_and_stop;
  end
endmodule // timer_event_counter_pfd_test
